// ### hdl/svs_defines.vh
// Timing and layout constants for the supply voltage supervisor.
// Assumes a 125 MHz system clock; included by the design files by bare name.
`ifndef SVS_DEFINES_VH
`define SVS_DEFINES_VH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define SVS_CLK_MHZ         125
// Deglitch window 8..20 us: aim at the middle, 14 us
`define SVS_DEG_MIN_US      8
`define SVS_DEG_MAX_US      20
`define SVS_DEG_NOM_US      14
`define SVS_DEG_CYC         (`SVS_DEG_NOM_US * `SVS_CLK_MHZ)
// Short-to-ground 2.7..3.3 ms, nominal 3.0 ms (in us)
`define SVS_STG_NOM_US      3000
`define SVS_STG_CYC         (`SVS_STG_NOM_US * `SVS_CLK_MHZ)

// ------------------------------------------------------------
// Channel layout
// ------------------------------------------------------------
`define SVS_NCH             5
`define SVS_CH_FIRST_BUCK        0
`define SVS_CH_SECOND_BUCK        1
`define SVS_CH_BOOST        2
`define SVS_CH_EXT1         3
`define SVS_CH_EXT2         4
`define SVS_EXT_BASE        3

`endif

// ### hdl/svs_chan.v
// One rail monitor channel: deglitch and short-to-ground timers.
// Assumes comparator inputs are already synchronised to i_clk_sys.
`timescale 1ns/100ps
`default_nettype none
`include "svs_defines.vh"

module svs_chan #(
  parameter integer DEG_CYC = `SVS_DEG_CYC,
  parameter integer STG_CYC = `SVS_STG_CYC,
  parameter integer HAS_DUV = 1
) (
  input  wire i_clk_sys,   // System clock
  input  wire i_sys_rst,   // Sync reset, active high
  input  wire i_en,        // Rail enabled
  input  wire i_uv,        // Below undervoltage level
  input  wire i_ov,        // Above overvoltage level
  input  wire i_duv,       // Below deep undervoltage level
  output reg  o_uv_evt,    // Undervoltage event pulse
  output reg  o_ov_evt,    // Overvoltage event pulse
  output reg  o_stg_evt    // Short-to-ground event pulse
);

  reg [31:0] uv_cnt_q;
  reg [31:0] ov_cnt_q;
  reg [31:0] duv_cnt_q;
  reg [31:0] stg_cnt_q;
  wire       duv_act;

  assign duv_act = (HAS_DUV != 0) && i_duv;

  // ------------------------------------------------------------
  // Timers: each restarts as soon as its condition goes away
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    o_uv_evt  <= 1'b0;
    o_ov_evt  <= 1'b0;
    o_stg_evt <= 1'b0;
    if (i_sys_rst || !i_en) begin
      uv_cnt_q  <= 32'h0;
      ov_cnt_q  <= 32'h0;
      duv_cnt_q <= 32'h0;
      stg_cnt_q <= 32'h0;
    end else begin
      if (!i_uv) begin
        uv_cnt_q <= 32'h0;
      end else if (uv_cnt_q < DEG_CYC) begin
        uv_cnt_q <= uv_cnt_q + 32'h1;
        o_uv_evt <= (uv_cnt_q == DEG_CYC - 1);
      end
      if (!i_ov) begin
        ov_cnt_q <= 32'h0;
      end else if (ov_cnt_q < DEG_CYC) begin
        ov_cnt_q <= ov_cnt_q + 32'h1;
        o_ov_evt <= (ov_cnt_q == DEG_CYC - 1);
      end
      if (!i_uv) begin
        stg_cnt_q <= 32'h0;
      end else if (stg_cnt_q < STG_CYC) begin
        stg_cnt_q <= stg_cnt_q + 32'h1;
      end
      if (!duv_act) begin
        duv_cnt_q <= 32'h0;
      end else if (duv_cnt_q < DEG_CYC) begin
        duv_cnt_q <= duv_cnt_q + 32'h1;
      end
      // Either path fires the short-to-ground event once
      o_stg_evt <= (i_uv && (stg_cnt_q == STG_CYC - 1)) ||
                   (duv_act && (duv_cnt_q == DEG_CYC - 1));
    end
  end

endmodule
`default_nettype wire

// ### hdl/svs_top.v
// Supply voltage supervisor: rail monitors, battery and reference checks.
// Assumes analog comparator levels arrive asynchronously on pins.
`timescale 1ns/100ps
`default_nettype none
`include "svs_defines.vh"

module svs_top #(
  parameter integer DEG_CYC = `SVS_DEG_CYC,   // Deglitch time in cycles
  parameter integer STG_CYC = `SVS_STG_CYC    // Short-to-ground time in cycles
) (
  input  wire       i_clk_sys,        // System clock, 125 MHz
  input  wire       i_sys_rst,        // Sync reset, active high
  input  wire       i_batt_uv,        // Battery below undervoltage level
  input  wire [2:0] i_conv_en,        // Converter rail enables
  input  wire [2:0] i_conv_uv,        // Converter undervoltage comparators
  input  wire [2:0] i_conv_ov,        // Converter overvoltage comparators
  input  wire [1:0] i_buck_duv,       // Buck deep undervoltage comparators
  input  wire [1:0] i_ext_en_req,     // External rail enable requests
  input  wire [1:0] i_ext_uv,         // External undervoltage comparators
  input  wire [1:0] i_ext_ov,         // External overvoltage comparators
  input  wire       i_ref_warn,       // Reference difference above warn limit
  input  wire       i_ref_fault,      // Reference difference above fault limit
  input  wire       i_ref_cause,      // Root cause: 0 selects a, 1 selects b
  input  wire       i_flag_clr,       // Clear all sticky flags
  output reg        o_batt_uv_flag,   // Battery undervoltage flag
  output reg  [4:0] o_uv_flag,        // Undervoltage flags per channel
  output reg  [4:0] o_ov_flag,        // Overvoltage flags per channel
  output reg  [4:0] o_stg_flag,       // Short-to-ground flags per channel
  output reg  [1:0] o_ext_en,         // External rail enable outputs
  output reg        o_ref_warn_flag_a, // Reference warning flag a
  output reg        o_ref_warn_flag_b, // Reference warning flag b
  output reg        o_ref_fault_flag_a, // Reference fault flag a
  output reg        o_ref_fault_flag_b, // Reference fault flag b
  output reg        o_irq,            // Warning interrupt pulse
  output reg        o_fault_state,    // Device in fault state
  output reg        o_shutdown        // Shut down all regulators
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam integer SW = 21;
  wire [SW-1:0] raw_in;
  reg  [SW-1:0] sync1_q;
  reg  [SW-1:0] sync2_q;

  assign raw_in = {i_batt_uv, i_conv_uv, i_conv_ov, i_buck_duv,
                   i_ext_uv, i_ext_ov, i_ref_warn, i_ref_fault, i_ref_cause,
                   i_conv_en, i_ext_en_req};

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync1_q <= {SW{1'b0}};
      sync2_q <= {SW{1'b0}};
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire       s_batt_uv = sync2_q[20];
  wire [2:0] s_conv_uv = sync2_q[19:17];
  wire [2:0] s_conv_ov = sync2_q[16:14];
  wire [1:0] s_duv     = sync2_q[13:12];
  wire [1:0] s_ext_uv  = sync2_q[11:10];
  wire [1:0] s_ext_ov  = sync2_q[9:8];
  wire       s_warn    = sync2_q[7];
  wire       s_fault   = sync2_q[6];
  wire       s_cause   = sync2_q[5];
  wire [2:0] s_conv_en = sync2_q[4:2] & {3{~o_shutdown}};
  wire [1:0] s_ext_req = sync2_q[1:0];

  // ------------------------------------------------------------
  // Per channel monitors
  // ------------------------------------------------------------
  wire [4:0] ch_en;
  wire [4:0] ch_uv;
  wire [4:0] ch_ov;
  wire [4:0] ch_duv;
  wire [4:0] uv_evt;
  wire [4:0] ov_evt;
  wire [4:0] stg_evt;

  assign ch_en  = {o_ext_en, s_conv_en};
  assign ch_uv  = {s_ext_uv, s_conv_uv};
  assign ch_ov  = {s_ext_ov, s_conv_ov};
  assign ch_duv = {3'h0, s_duv};

  genvar g;
  generate
    for (g = 0; g < `SVS_NCH; g = g + 1) begin : g_ch
      svs_chan #(
        .DEG_CYC (DEG_CYC),
        .STG_CYC (STG_CYC),
        .HAS_DUV ((g == `SVS_CH_FIRST_BUCK || g == `SVS_CH_SECOND_BUCK) ? 1 : 0)
      ) u_chan (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_en      (ch_en[g]),
        .i_uv      (ch_uv[g]),
        .i_ov      (ch_ov[g]),
        .i_duv     (ch_duv[g]),
        .o_uv_evt  (uv_evt[g]),
        .o_ov_evt  (ov_evt[g]),
        .o_stg_evt (stg_evt[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Sticky flags: a new event beats a simultaneous clear
  // ------------------------------------------------------------
  reg        warn_q;
  // Latched trip per rail, released when the request is withdrawn
  reg  [1:0] ext_off_q;
  reg  [1:0] ext_en_d;
  integer    k;
  integer    j;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_batt_uv_flag     <= 1'b0;
      o_uv_flag          <= 5'h0;
      o_ov_flag          <= 5'h0;
      o_stg_flag         <= 5'h0;
      o_ref_warn_flag_a  <= 1'b0;
      o_ref_warn_flag_b  <= 1'b0;
      o_ref_fault_flag_a <= 1'b0;
      o_ref_fault_flag_b <= 1'b0;
    end else begin
      o_batt_uv_flag <= s_batt_uv | (o_batt_uv_flag & ~i_flag_clr);
      o_uv_flag  <= uv_evt  | (o_uv_flag  & {5{~i_flag_clr}});
      o_ov_flag  <= ov_evt  | (o_ov_flag  & {5{~i_flag_clr}});
      o_stg_flag <= stg_evt | (o_stg_flag & {5{~i_flag_clr}});
      o_ref_warn_flag_a  <= (s_warn & ~s_cause) |
                            (o_ref_warn_flag_a & ~i_flag_clr);
      o_ref_warn_flag_b  <= (s_warn & s_cause) |
                            (o_ref_warn_flag_b & ~i_flag_clr);
      o_ref_fault_flag_a <= (s_fault & ~s_cause) |
                            (o_ref_fault_flag_a & ~i_flag_clr);
      o_ref_fault_flag_b <= (s_fault & s_cause) |
                            (o_ref_fault_flag_b & ~i_flag_clr);
    end
  end

  // ------------------------------------------------------------
  // Reference comparison, fault state and rail protection
  // ------------------------------------------------------------
  // Fault state is left only by reset: operation cannot be trusted
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      warn_q        <= 1'b0;
      o_irq         <= 1'b0;
      o_fault_state <= 1'b0;
      o_shutdown    <= 1'b0;
      o_ext_en      <= 2'h0;
    end else begin
      warn_q <= s_warn;
      o_irq  <= s_warn & ~warn_q;
      if (s_fault) begin
        o_fault_state <= 1'b1;
        o_shutdown    <= 1'b1;
      end
      // Rail stays off until its request drops and returns
      o_ext_en <= ext_en_d;
    end
  end

  always @* begin
    ext_en_d = 2'h0;
    for (k = 0; k < 2; k = k + 1) begin
      if (o_shutdown || s_fault || !s_ext_req[k]) begin
        ext_en_d[k] = 1'b0;
      end else if (ov_evt[`SVS_EXT_BASE + k] || stg_evt[`SVS_EXT_BASE + k]) begin
        ext_en_d[k] = 1'b0;
      end else if (!ext_off_q[k]) begin
        ext_en_d[k] = 1'b1;
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ext_off_q <= 2'h0;
    end else begin
      for (j = 0; j < 2; j = j + 1) begin
        if (ov_evt[`SVS_EXT_BASE + j] || stg_evt[`SVS_EXT_BASE + j]) begin
          ext_off_q[j] <= 1'b1;
        end else if (!s_ext_req[j]) begin
          ext_off_q[j] <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### dv/svs_props.sv
// Port checker for svs_top, bound below.
// Assumes the bench shortens DEG_CYC and STG_CYC.
`timescale 1ns/100ps
`default_nettype none
module svs_props #(
  parameter integer DEG_CYC = 8,
  parameter integer STG_CYC = 40
) (
  input wire logic       i_clk_sys,          // Clock
  input wire logic       i_sys_rst,          // Reset
  input wire logic       i_batt_uv,          // Battery low
  input wire logic [2:0] i_conv_en,          // Rail enables
  input wire logic [2:0] i_conv_uv,          // UV comparators
  input wire logic [1:0] i_buck_duv,         // Deep UV
  input wire logic       i_ref_warn,         // Warn level
  input wire logic       i_ref_fault,        // Fault level
  input wire logic       i_ref_cause,        // Root cause
  input wire logic       o_batt_uv_flag,     // Battery flag
  input wire logic [4:0] o_uv_flag,          // UV flags
  input wire logic [4:0] o_ov_flag,          // OV flags
  input wire logic [4:0] o_stg_flag,         // StG flags
  input wire logic [1:0] o_ext_en,           // Ext enables
  input wire logic       o_ref_warn_flag_a,  // Warn flag a
  input wire logic       o_irq,              // Warn pulse
  input wire logic       o_fault_state,      // Fault state
  input wire logic       o_shutdown          // Shutdown
);
  int uv_q;
  int duv_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Steady-condition run lengths; shutdown stops monitoring
  always @(posedge i_clk_sys) begin
    uv_q <= (i_sys_rst || o_shutdown || !(i_conv_en[0] && i_conv_uv[0])) ? 0 : uv_q + 1;
    duv_q <= (i_sys_rst || o_shutdown || !(i_conv_en[0] && i_buck_duv[0])) ? 0 : duv_q + 1;
  end
  chk_batt_flag:
  assert property (i_batt_uv [*3] |-> ##[0:3] o_batt_uv_flag) else $error("battery flag late");
  chk_no_glitch:
  assert property ($rose(o_uv_flag[1]) |-> $past(i_conv_uv[1], 4) && $past(i_conv_uv[1], DEG_CYC + 3))
    else $error("uv flag without steady input");
  chk_uv_time:
  assert property (uv_q == DEG_CYC + 4 |-> ##[0:2] o_uv_flag[0]) else $error("uv flag late");
  chk_stg_time:
  assert property ($rose(o_stg_flag[2]) |-> $past(i_conv_uv[2], 4) && $past(i_conv_uv[2], STG_CYC + 3))
    else $error("stg flag early");
  chk_duv_stg:
  assert property (duv_q == DEG_CYC + 4 |-> ##[0:2] o_stg_flag[0]) else $error("deep uv stg late");
  chk_off_quiet:
  assert property ($rose(o_uv_flag[1]) || $rose(o_ov_flag[1]) |-> $past(i_conv_en[1], 4))
    else $error("event on disabled rail");
  chk_ext_trip:
  assert property ($rose(o_ov_flag[3] || o_stg_flag[3]) |=> !o_ext_en[0] [*3])
    else $error("ext rail not switched off");
  chk_irq_src:
  assert property (o_irq |-> $past(i_ref_warn, 3) ##1 !o_irq) else $error("bad irq pulse");
  chk_warn_cause:
  assert property (o_irq && !$past(i_ref_cause, 3) |-> o_ref_warn_flag_a) else $error("warn flag a");
  chk_fault_hold:
  assert property (o_shutdown |-> ##2 (o_shutdown && o_fault_state)) else $error("fault not held");
  chk_fault_time:
  assert property (i_ref_fault [*3] |-> ##[0:3] o_shutdown) else $error("shutdown late");
  cover property ($rose(o_stg_flag[2]));
  cover property (o_irq);
  cover property ($fell(o_ext_en[0]));
endmodule
bind svs_top svs_props #(.DEG_CYC(DEG_CYC), .STG_CYC(STG_CYC)) u_svs_props (.*);
`default_nettype wire

// ### dv/svs_host.sv
// Host model: reads the status flags and clears them.
// Assumes one read request is a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
module svs_host (
  input  wire logic        i_clk_sys,  // Clock
  input  wire logic        i_rd_req,   // Read-and-clear request
  input  wire logic [22:0] i_flags,    // Status flags
  output var  logic [22:0] o_snap,     // Last value read
  output var  logic        o_clr = 0   // Clear strobe
);
  // Clear follows the read by one cycle, so a flag set on the read edge is cleared unread
  always @(posedge i_clk_sys) begin
    o_clr <= i_rd_req;
    if (i_rd_req) o_snap <= i_flags;
  end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for svs_top with short timer counts.
// Assumes the host model and bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam integer DEG = 8;
  localparam integer STG = 40;
  logic i_clk_sys = 0, i_sys_rst = 1, i_batt_uv = 0, i_flag_clr, rd_req = 0;
  logic [2:0] i_conv_en = 0, i_conv_uv = 0, i_conv_ov = 0;
  logic [1:0] i_buck_duv = 0, i_ext_en_req = 0, i_ext_uv = 0, i_ext_ov = 0, o_ext_en;
  logic i_ref_warn = 0, i_ref_fault = 0, i_ref_cause = 0, o_batt_uv_flag, o_irq;
  logic o_ref_warn_flag_a, o_ref_warn_flag_b, o_ref_fault_flag_a, o_ref_fault_flag_b;
  logic o_fault_state, o_shutdown;
  logic [4:0] o_uv_flag, o_ov_flag, o_stg_flag;
  logic [22:0] vec, prev = 0, snap, exp_v, snap_exp;
  logic [22:0] q[$];
  int n_fail = 0, comparisons = 0, cyc_n = 0, len;
  assign vec = {o_batt_uv_flag, o_uv_flag, o_ov_flag, o_stg_flag, o_ext_en, o_ref_warn_flag_a,
                o_ref_warn_flag_b, o_ref_fault_flag_a, o_ref_fault_flag_b, o_shutdown};
  svs_top #(.DEG_CYC(DEG), .STG_CYC(STG)) u_svs_top (.*);
  svs_host u_svs_host (.i_clk_sys(i_clk_sys), .i_rd_req(rd_req), .i_flags(vec),
                       .o_snap(snap), .o_clr(i_flag_clr));
  always #4 i_clk_sys = ~i_clk_sys;
  task automatic check(input logic [22:0] seen, input logic [22:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic push;
    q.push_back(exp_v);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Any flag change takes the oldest note; an unexpected change fails
  always @(negedge i_clk_sys) begin
    prev <= vec;
    if (!i_sys_rst && vec !== prev) begin
      if (q.size() == 0) check(vec, prev);
      else check(vec, q.pop_front());
    end
  end
  always @(posedge i_clk_sys) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32670));
    cyc(8);
    i_sys_rst <= 0;
    cyc(2);
    i_conv_en <= 3'h7;
    i_ext_en_req <= 2'h3;
    exp_v = 0; exp_v[6:5] = 2'h3; push();
    cyc(10);
    repeat (4) begin
      len = 1 + $urandom % (DEG - 2);
      i_conv_uv[1] <= 1; cyc(len); i_conv_uv[1] <= 0; cyc(1);
    end
    i_batt_uv <= 1; exp_v[22] = 1; push(); cyc(5); i_batt_uv <= 0; cyc(4);
    for (int c = 0; c < 3; c++) begin
      i_conv_ov[c] <= 1; exp_v[12 + c] = 1; push();
      cyc(DEG + 6); i_conv_ov[c] <= 0; cyc(4);
    end
    i_conv_en[1] <= 0; cyc(4); i_conv_uv[1] <= 1; cyc(STG + 10);
    i_conv_uv[1] <= 0; cyc(4); i_conv_en[1] <= 1;
    i_conv_uv[2] <= 1; exp_v[19] = 1; push(); exp_v[9] = 1; push();
    cyc(STG + 10); i_conv_uv[2] <= 0; cyc(4);
    i_conv_uv[0] <= 1; i_buck_duv[0] <= 1; exp_v[17] = 1; exp_v[7] = 1; push();
    cyc(DEG + 6); i_conv_uv[0] <= 0; i_buck_duv[0] <= 0; cyc(4);
    i_ext_ov[0] <= 1; exp_v[15] = 1; exp_v[5] = 0; push();
    cyc(DEG + 6); i_ext_ov[0] <= 0; cyc(4);
    i_ext_en_req[0] <= 0; cyc(4); i_ext_en_req[0] <= 1; exp_v[5] = 1; push(); cyc(6);
    i_ext_uv[1] <= 1; exp_v[21] = 1; push();
    exp_v[11] = 1; exp_v[6] = 0; push(); cyc(STG + 10); i_ext_uv[1] <= 0; cyc(4);
    snap_exp = exp_v; rd_req <= 1; cyc(1); rd_req <= 0;
    exp_v[22:7] = 0; push(); cyc(3);
    check(snap, snap_exp);
    len = $urandom % 2; i_ref_cause <= len[0]; i_ref_warn <= 1;
    exp_v[4 - len] = 1; push(); cyc(3); i_ref_warn <= 0; cyc(4);
    i_ext_en_req <= 0; exp_v[6:5] = 0; push(); cyc(5);
    len = $urandom % 2; i_ref_cause <= len[0]; i_ref_fault <= 1;
    exp_v[2 - len] = 1; exp_v[0] = 1; push(); cyc(8);
    check({22'h0, q.size() != 0}, 23'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
